// ### inc/esg_cfg.svh
`ifndef ESG_CFG_SVH
`define ESG_CFG_SVH

// ---------------------------------------------------------------
// Clock and crystal timing
// ---------------------------------------------------------------
// Reference clock period in ps (200 MHz)
`define ESG_REF_PERIOD_PS 5000
// Crystal clock period in ps, modelled as two reference cycles
`define ESG_XTAL_PERIOD_PS 10000
`define ESG_REF_PER_XTAL (`ESG_XTAL_PERIOD_PS / `ESG_REF_PERIOD_PS)

// ---------------------------------------------------------------
// Bus cycle shape, in crystal units
// ---------------------------------------------------------------
// Latch strobe period in crystal cycles
`define ESG_BUS_XTAL 4
// Latch strobe width in half crystal cycles (1.5 cycles)
`define ESG_ALE_HALF_XTAL 3
// Program strobe falls this many half crystal cycles into a bus cycle
`define ESG_PROG_HALF_XTAL 4

// Derived counts in reference cycles
`define ESG_BUS_REF (`ESG_BUS_XTAL * `ESG_REF_PER_XTAL)
`define ESG_ALE_REF ((`ESG_ALE_HALF_XTAL * `ESG_REF_PER_XTAL) / 2)
`define ESG_PROG_FIRST ((`ESG_PROG_HALF_XTAL * `ESG_REF_PER_XTAL) / 2)
`define ESG_PHASE_W 3
`define ESG_PHASE_LAST (`ESG_BUS_REF - 1)

// Reset levels of the strobes
`define ESG_ALE_RST 1'h1
`define ESG_PROG_RST 1'h1

`endif

// ### inc/esg_pkg.sv
`default_nettype none

package esg_pkg;
  typedef enum logic {ESG_MUX_MODE, ESG_DEMUX_MODE} esg_mode_type;
  typedef enum {ESG_CAPTURE, ESG_RUN} esg_state_type;
endpackage

`default_nettype wire

// ### inc/esg_phase_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "esg_cfg.svh"

interface esg_phase_if;
  logic run;
  logic [`ESG_PHASE_W-1:0] phase;
  logic cycleEnd;
  modport gen (input run, output phase, output cycleEnd);
  modport use_side (output run, input phase, input cycleEnd);
endinterface

`default_nettype wire

// ### rtl/esg_phase_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "esg_cfg.svh"

module esg_phase_gen (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Phase bus
  esg_phase_if.gen ph
);
  logic [`ESG_PHASE_W-1:0] phase;
  wire atLast = (phase == `ESG_PHASE_W'(`ESG_PHASE_LAST));
  wire [`ESG_PHASE_W-1:0] next_phase = atLast ? '0 : phase + `ESG_PHASE_W'(1);

  // Counter parks at zero until running so the first cycle is whole
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= '0;
    end else if (ph.run) begin
      phase <= next_phase;
    end
  end

  assign ph.phase = phase;
  assign ph.cycleEnd = ph.run && atLast;
endmodule

`default_nettype wire

// ### rtl/external_bus_strobe_gen.sv
// Behaviour
// - Strap low: latch strobe clocks the low address byte off the muxed port.
// - Latch strobe high for 1.5 crystal cycles, repeating every four crystal cycles.
// - Strap high and suppress clear: latch strobe keeps toggling.
// - Latch strobe held high in reset, and when suppress set with strap high.
// - Program-store strobe is chip enable for external program or merged memory.
// - Program-store strobe pulses low on external access, otherwise high.
// - Strap sampled only on the first clock after reset release; high demuxed, low multiplexed.
`timescale 1ns/1ps
`default_nettype none
`include "esg_cfg.svh"

module external_bus_strobe_gen (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Straps and control
  input wire logic bus_mode_strap,
  input wire logic strobe_suppress,
  // Core access request
  input wire logic extAccessReq,
  output logic extAccessAck,
  // External bus strobes
  output logic addrLatchStrobe,
  output logic program_store_strobe_n,
  // Status
  output logic demuxMode
);
  esg_phase_if ph ();
  esg_pkg::esg_state_type state;
  esg_pkg::esg_mode_type busMode;
  logic accessActive;

  esg_phase_gen u_phase (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .ph(ph)
  );

  // ---------------------------------------------------------------
  // Strap capture
  // ---------------------------------------------------------------
  wire running = (state == esg_pkg::ESG_RUN);
  assign ph.run = running;

  // Strap is caught on the first edge after release, never under reset
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= esg_pkg::ESG_CAPTURE;
      busMode <= esg_pkg::ESG_MUX_MODE;
    end else begin
      unique case (state)
        esg_pkg::ESG_CAPTURE: begin
          busMode <= bus_mode_strap ? esg_pkg::ESG_DEMUX_MODE : esg_pkg::ESG_MUX_MODE;
          state <= esg_pkg::ESG_RUN;
        end
        esg_pkg::ESG_RUN: begin
          state <= esg_pkg::ESG_RUN;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Strobe decode
  // ---------------------------------------------------------------
  wire isDemux = (busMode == esg_pkg::ESG_DEMUX_MODE);
  // Suppress only counts in demuxed mode; muxed mode needs the strobe
  wire aleForced = !running || (isDemux && strobe_suppress);
  wire aleWindow = (ph.phase < `ESG_PHASE_W'(`ESG_ALE_REF));
  wire next_ale = aleForced ? `ESG_ALE_RST : aleWindow;
  wire pseWindow = (ph.phase >= `ESG_PHASE_W'(`ESG_PROG_FIRST));
  wire next_progStrobe = !(running && accessActive && pseWindow);
  wire takeAccess = ph.cycleEnd && extAccessReq;

  // ---------------------------------------------------------------
  // Access handshake
  // ---------------------------------------------------------------
  // A request is taken at the end of a bus cycle and owns the next one
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      accessActive <= 1'h0;
      extAccessAck <= 1'h0;
    end else begin
      if (ph.cycleEnd) begin
        accessActive <= extAccessReq;
      end
      extAccessAck <= takeAccess;
    end
  end

  // ---------------------------------------------------------------
  // Output flops
  // ---------------------------------------------------------------
  // Strobes come straight from flops to avoid glitches at the pins
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      addrLatchStrobe <= `ESG_ALE_RST;
      program_store_strobe_n <= `ESG_PROG_RST;
      demuxMode <= 1'h0;
    end else begin
      addrLatchStrobe <= next_ale;
      program_store_strobe_n <= next_progStrobe;
      demuxMode <= isDemux;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_mux_strobe_runs;
    (running && !isDemux) |-> ##[1:8] $fell(addrLatchStrobe);
  endproperty
  a_mux_strobe_runs: assert property (p_mux_strobe_runs) else $error("latch strobe idle in muxed mode");

  property p_ale_shape;
    (!isDemux && $rose(addrLatchStrobe)) |-> addrLatchStrobe[*3] ##1 (!addrLatchStrobe)[*5] ##1 $rose(addrLatchStrobe);
  endproperty
  a_ale_shape: assert property (p_ale_shape) else $error("latch strobe width or period wrong");

  property p_demux_toggle;
    (running && isDemux && !strobe_suppress && $fell(addrLatchStrobe)) |-> !addrLatchStrobe[*5];
  endproperty
  a_demux_toggle: assert property (p_demux_toggle) else $error("latch strobe low time wrong");

  property p_ale_forced;
    ((running && isDemux && strobe_suppress) || !running) |=> addrLatchStrobe;
  endproperty
  a_ale_forced: assert property (p_ale_forced) else $error("latch strobe not held high");

  property p_prog_only_access;
    !program_store_strobe_n |-> $past(accessActive);
  endproperty
  a_prog_only_access: assert property (p_prog_only_access) else $error("program strobe low without access");

  property p_prog_pulse;
    (running && accessActive && ph.phase == `ESG_PHASE_W'(`ESG_PROG_FIRST)) |=> (!program_store_strobe_n)[*4];
  endproperty
  a_prog_pulse: assert property (p_prog_pulse) else $error("program strobe pulse too short");

  property p_strap_held;
    running |=> $stable(busMode);
  endproperty
  a_strap_held: assert property (p_strap_held) else $error("bus mode changed after capture");

  property p_mode_capture;
    !running |=> (isDemux == $past(bus_mode_strap));
  endproperty
  a_mode_capture: assert property (p_mode_capture) else $error("bus mode not taken from strap");

  property p_ack_at_end;
    extAccessAck |-> $past(ph.cycleEnd);
  endproperty
  a_ack_at_end: assert property (p_ack_at_end) else $error("access ack outside bus cycle end");

  property p_ack_single;
    extAccessAck |=> !extAccessAck;
  endproperty
  a_ack_single: assert property (p_ack_single) else $error("access ack longer than one cycle");

  property p_prog_idle_high;
    (running && !accessActive) |=> program_store_strobe_n;
  endproperty
  a_prog_idle_high: assert property (p_prog_idle_high) else $error("program strobe low while idle");

  property p_prog_high_early;
    (running && ph.phase < `ESG_PHASE_W'(`ESG_PROG_FIRST)) |=> program_store_strobe_n;
  endproperty
  a_prog_high_early: assert property (p_prog_high_early) else $error("program strobe low too early");

  property p_ale_low_window;
    (running && !aleForced && ph.phase == `ESG_PHASE_W'(`ESG_ALE_REF)) |=> !addrLatchStrobe;
  endproperty
  a_ale_low_window: assert property (p_ale_low_window) else $error("latch strobe too wide");

  property p_ale_high_start;
    (running && !aleForced && ph.phase == '0) |=> addrLatchStrobe;
  endproperty
  a_ale_high_start: assert property (p_ale_high_start) else $error("latch strobe missing at cycle start");

  property p_mux_no_suppress;
    (running && !isDemux && strobe_suppress && ph.phase == `ESG_PHASE_W'(`ESG_ALE_REF)) |=> !addrLatchStrobe;
  endproperty
  a_mux_no_suppress: assert property (p_mux_no_suppress) else $error("strobe stopped in muxed mode");

  property p_phase_wrap;
    (ph.phase == `ESG_PHASE_W'(`ESG_PHASE_LAST)) |=> (ph.phase == '0);
  endproperty
  a_phase_wrap: assert property (p_phase_wrap) else $error("bus cycle length wrong");

  property p_phase_parked;
    !running |-> (ph.phase == '0);
  endproperty
  a_phase_parked: assert property (p_phase_parked) else $error("bus phase moved before capture");

  property p_cov_mux;
    !isDemux && $fell(addrLatchStrobe);
  endproperty
  c_cov_mux: cover property (p_cov_mux);

  property p_cov_suppress;
    isDemux && strobe_suppress && running;
  endproperty
  c_cov_suppress: cover property (p_cov_suppress);

  property p_cov_access;
    $fell(program_store_strobe_n);
  endproperty
  c_cov_access: cover property (p_cov_access);

  property p_cov_demux_toggle;
    isDemux && !strobe_suppress && $fell(addrLatchStrobe);
  endproperty
  c_cov_demux_toggle: cover property (p_cov_demux_toggle);

  property p_cov_back_to_back;
    extAccessAck ##8 extAccessAck;
  endproperty
  c_cov_back_to_back: cover property (p_cov_back_to_back);
endmodule

`default_nettype wire

// ### tb/esg_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module esg_mem_model (
  // Strobes from the device
  input wire logic rst_b,
  input wire logic addrLatchStrobe,
  input wire logic program_store_strobe_n,
  // Observed traffic
  output var int latchCount,
  output var int enableCount
);
  // Transparent latch closes on the falling strobe
  always @(negedge addrLatchStrobe or negedge rst_b) latchCount <= rst_b ? latchCount + 1 : 0;
  always @(negedge program_store_strobe_n or negedge rst_b) enableCount <= rst_b ? enableCount + 1 : 0;
endmodule

`default_nettype wire

// ### tb/test_external_bus_strobe_gen.sv
`timescale 1ns/1ps
`default_nettype none

module test_external_bus_strobe_gen;
  logic ref_clk = 1'h0;
  logic rst_b = 1'h0;
  logic bus_mode_strap = 1'h0;
  logic strobe_suppress = 1'h0;
  logic extAccessReq = 1'h0;
  logic extAccessAck, addrLatchStrobe, program_store_strobe_n, demuxMode;
  logic takeNow, owned, toggling;
  int latchCount, enableCount, o, expLatch, expEn;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;

  external_bus_strobe_gen u_external_bus_strobe_gen (.ref_clk(ref_clk), .rst_b(rst_b),
    .bus_mode_strap(bus_mode_strap), .strobe_suppress(strobe_suppress), .extAccessReq(extAccessReq),
    .extAccessAck(extAccessAck), .addrLatchStrobe(addrLatchStrobe),
    .program_store_strobe_n(program_store_strobe_n), .demuxMode(demuxMode));
  esg_mem_model u_esg_mem_model (.rst_b(rst_b), .addrLatchStrobe(addrLatchStrobe),
    .program_store_strobe_n(program_store_strobe_n), .latchCount(latchCount), .enableCount(enableCount));

  initial forever #2.5 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("Comparisons %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Latch strobe high for the first three phases of each bus cycle
  function automatic logic exp_ale(input int pos, input logic tog);
    return tog ? (pos < 3) : 1'h1;
  endfunction

  // Program strobe low for the last four phases of an owned bus cycle
  function automatic logic exp_prog_n(input int pos, input logic own);
    return !(pos >= 4 && own);
  endfunction

  // ---------------------------------------------------------------
  // One reset, then bus cycles checked against a phase model
  // ---------------------------------------------------------------
  task automatic run_seg(input logic strap, input logic supp);
    rst_b = 1'h0;
    bus_mode_strap = strap;
    strobe_suppress = supp;
    extAccessReq = 1'h0;
    repeat (2) @(negedge ref_clk);
    chk({addrLatchStrobe, program_store_strobe_n, extAccessAck, demuxMode}, 4'hC);
    rst_b = 1'h1;
    @(negedge ref_clk);
    // Strap flips after capture and must not change the mode
    bus_mode_strap = ~strap;
    toggling = !(strap && supp);
    {owned, takeNow} = 2'h0;
    expLatch = 0;
    expEn = 0;
    for (int k = 2; k < 90; k++) begin
      @(negedge ref_clk);
      o = (k - 2) % 8;
      if (o == 0) owned = takeNow;
      if (o == 3 && toggling) expLatch++;
      if (o == 4 && owned) expEn++;
      chk(addrLatchStrobe, exp_ale(o, toggling));
      // Ack shows in the last phase of the bus cycle whose end took the request
      chk(extAccessAck, o == 7 && extAccessReq);
      chk(program_store_strobe_n, exp_prog_n(o, owned));
      chk(demuxMode, strap);
      if (o == 7) takeNow = extAccessReq;
      // Request changes mid-cycle only, held across the take edge until acked
      if (o == 3) extAccessReq = k < 30 ? 1'h1 : 1'($urandom % 2);
    end
    chk(latchCount, expLatch);
    chk(enableCount, expEn);
  endtask

  initial begin
    void'($urandom(98441));
    for (int s = 0; s < 4; s++) run_seg(s[1], s[0]);
    run_seg(1'($urandom % 2), 1'($urandom % 2));
    end_sim();
  end
endmodule

`default_nettype wire
